// >>> ddr2_ctl_pkg.sv
// Shared constants and types for the DDR2 control pin interface
package ddr2_ctl_pkg;
	localparam int DQ_W = 8;
	localparam int CTL_W = 6;
	localparam int CTL_CKE = 5;
	localparam int CTL_CS = 4;
	localparam int CTL_RAS = 3;
	localparam int CTL_CAS = 2;
	localparam int CTL_WE = 1;
	localparam int CTL_ODT = 0;
	localparam logic [CTL_W-1:0] CTL_RESET = 6'h1E;
	localparam logic [1:0] ORG_X4 = 2'h0;
	localparam logic [1:0] ORG_X8 = 2'h1;
	localparam logic [1:0] ORG_X16 = 2'h2;

	typedef enum logic [3:0] {
		CMD_MODE_SET = 4'h0,
		CMD_REFRESH = 4'h1,
		CMD_PRECHARGE = 4'h2,
		CMD_ACTIVATE = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_READ = 4'h5,
		CMD_RESERVED = 4'h6,
		CMD_NOP = 4'h7,
		CMD_DESELECT = 4'h8
	} cmd_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'h0,
		PWR_PRE_PD = 2'h1,
		PWR_ACT_PD = 2'h2,
		PWR_SELF_REF = 2'h3
	} pwr_t;
endpackage

// >>> edge_if.sv
// Synchronised level and edge pulses of one sampled pin
`timescale 1ns/1ps
interface edge_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// >>> sync_edge.sv
// Two-stage synchroniser with edge detection for a strobe pin
`timescale 1ns/1ps
module sync_edge (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic pin,
	edge_if.src e
);
	logic meta;
	logic stable;
	logic last;

	// Edge detect looks only at the second stage, never the metastable one
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta <= 1'b0;
			stable <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= pin;
			stable <= meta;
			last <= stable;
		end
	end

	assign e.level = stable;
	assign e.rise = stable & ~last;
	assign e.fall = ~stable & last;
endmodule

// >>> ddr2_ctl_pins.sv
// DDR2 control pin interface: sampling, power states, decode, termination, masking
`timescale 1ns/1ps
module ddr2_ctl_pins
	import ddr2_ctl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic odt,
	input wire logic [DQ_W-1:0] dq_i,
	output logic [DQ_W-1:0] dq_o,
	output logic dq_oe,
	input wire logic dqs_i,
	output logic dqs_o,
	output logic dqs_oe,
	output logic dqs_n_o,
	output logic dqs_n_oe,
	input wire logic dm_i,
	output logic dm_o,
	output logic dm_oe,
	input wire logic [1:0] org,
	input wire logic emr_odt_disable,
	input wire logic emr_rdqs_enable,
	input wire logic emr_dqs_n_disable,
	input wire logic row_open,
	input wire logic rd_valid,
	input wire logic [DQ_W-1:0] rd_rise_data,
	input wire logic [DQ_W-1:0] rd_fall_data,
	input wire logic wr_window,
	output logic cmd_valid,
	output cmd_t cmd,
	output pwr_t pwr_state,
	output logic int_clk_en,
	output logic in_buf_en,
	output logic out_drv_en,
	output logic ck_buf_en,
	output logic term_dq,
	output logic term_dqs,
	output logic term_dqs_n,
	output logic term_dm,
	output logic term_rdqs,
	output logic [DQ_W-1:0] wr_data,
	output logic wr_store
);
	edge_if ck_e ();
	edge_if dqs_e ();
	logic [CTL_W-1:0] ctl_m;
	logic [CTL_W-1:0] ctl_s;
	logic [DQ_W:0] dat_m;
	logic [DQ_W:0] dat_s;
	logic cke_s;
	logic odt_s;
	logic dm_s;
	logic odt_reg;
	logic rdqs_mode;
	logic mask_en;
	logic active;
	cmd_t cmd_code;
	cmd_t next_cmd;

	// Only the true half of the clock pair is sampled; the crossing is its edge
	sync_edge u_ck_sync (.clk_sys(clk_sys), .rst(rst), .pin(ck), .e(ck_e.src));
	sync_edge u_dqs_sync (.clk_sys(clk_sys), .rst(rst), .pin(dqs_i), .e(dqs_e.src));

	// Same two-stage delay as the strobes keeps data aligned to its edges
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctl_m <= CTL_RESET;
			ctl_s <= CTL_RESET;
			dat_m <= '0;
			dat_s <= '0;
		end else begin
			ctl_m <= {cke, cs_n, ras_n, cas_n, we_n, odt};
			ctl_s <= ctl_m;
			dat_m <= {dm_i, dq_i};
			dat_s <= dat_m;
		end
	end

	assign cke_s = ctl_s[CTL_CKE];
	assign odt_s = ctl_s[CTL_ODT];
	assign dm_s = dat_s[DQ_W];
	assign active = (pwr_state == PWR_ACTIVE);

	always_comb begin
		next_cmd = CMD_DESELECT;
		if (!ctl_s[CTL_CS]) begin
			next_cmd = cmd_t'({1'b0, ctl_s[CTL_RAS], ctl_s[CTL_CAS], ctl_s[CTL_WE]});
		end
	end
	assign cmd_code = next_cmd;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_valid <= 1'b0;
			cmd <= CMD_DESELECT;
		end else begin
			cmd_valid <= 1'b0;
			if (ck_e.rise && active) begin
				cmd <= cmd_code;
				cmd_valid <= !ctl_s[CTL_CS];
			end
		end
	end

	// Power state; self refresh exit needs no clock edge since CK may be stopped
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwr_state <= PWR_ACTIVE;
		end else begin
			unique case (pwr_state)
				PWR_ACTIVE: begin
					if (ck_e.rise && !cke_s) begin
						if (row_open) begin
							pwr_state <= PWR_ACT_PD;
						end else if (cmd_code == CMD_REFRESH) begin
							pwr_state <= PWR_SELF_REF;
						end else begin
							pwr_state <= PWR_PRE_PD;
						end
					end
				end
				PWR_PRE_PD, PWR_ACT_PD: begin
					if (ck_e.rise && cke_s) begin
						pwr_state <= PWR_ACTIVE;
					end
				end
				PWR_SELF_REF: begin
					if (cke_s) begin
						pwr_state <= PWR_ACTIVE;
					end
				end
			endcase
		end
	end

	assign int_clk_en = active;
	assign in_buf_en = active;
	assign out_drv_en = active;
	assign ck_buf_en = (pwr_state != PWR_SELF_REF);

	// ODT buffer stays alive through power-down but not self refresh
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			odt_reg <= 1'b0;
		end else if (ck_e.rise && ck_buf_en) begin
			odt_reg <= odt_s && !emr_odt_disable;
		end
	end

	assign rdqs_mode = (org == ORG_X8) && emr_rdqs_enable;
	assign mask_en = !rdqs_mode;
	assign term_dq = odt_reg && !emr_odt_disable;
	assign term_dqs = term_dq;
	assign term_dqs_n = term_dq && !emr_dqs_n_disable;
	assign term_dm = term_dq && !rdqs_mode;
	assign term_rdqs = term_dq && rdqs_mode;

	// Read launch on both CK crossings; strobe is edge aligned with the data
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dq_o <= '0;
			dqs_o <= 1'b0;
		end else if (rd_valid && out_drv_en) begin
			if (ck_e.rise) begin
				dq_o <= rd_rise_data;
				dqs_o <= 1'b1;
			end else if (ck_e.fall) begin
				dq_o <= rd_fall_data;
				dqs_o <= 1'b0;
			end
		end else begin
			dqs_o <= 1'b0;
		end
	end

	assign dq_oe = rd_valid && out_drv_en;
	assign dqs_oe = dq_oe;
	assign dqs_n_o = ~dqs_o;
	assign dqs_n_oe = dq_oe && !emr_dqs_n_disable;
	assign dm_o = dqs_o;
	assign dm_oe = dq_oe && rdqs_mode;

	// Writes are only taken while awake; the controller keeps CKE high meanwhile
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_data <= '0;
			wr_store <= 1'b0;
		end else begin
			wr_store <= 1'b0;
			if ((dqs_e.rise || dqs_e.fall) && wr_window && active) begin
				wr_data <= dat_s[DQ_W-1:0];
				wr_store <= !(dm_s && mask_en);
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_cmd_on_rise: assert property (cmd_valid |-> $past(ck_e.rise))
		else $error("command taken without a CK rising edge");
	a_cs_masks_cmd: assert property (ck_e.rise && active && ctl_s[CTL_CS] |=> !cmd_valid)
		else $error("command accepted with chip select high");
	a_cmd_code_kept: assert property (ck_e.rise && active && !ctl_s[CTL_CS]
		|=> cmd_valid && cmd == $past(cmd_code))
		else $error("decoded command does not match pins");
	a_sr_exit_async: assert property (pwr_state == PWR_SELF_REF && cke_s
		|=> pwr_state == PWR_ACTIVE)
		else $error("self refresh did not exit on CKE high");
	a_pd_needs_edge: assert property (!ck_e.rise
		&& (pwr_state == PWR_PRE_PD || pwr_state == PWR_ACT_PD)
		|=> pwr_state == $past(pwr_state))
		else $error("power-down left without a clock edge");
	a_pd_kind: assert property (active && ck_e.rise && !cke_s && row_open
		|=> pwr_state == PWR_ACT_PD)
		else $error("open row did not give active power-down");
	a_odt_follows: assert property (ck_e.rise && ck_buf_en && !emr_odt_disable
		##1 !emr_odt_disable |-> term_dq == $past(odt_s))
		else $error("termination does not follow sampled ODT");
	a_odt_ignored: assert property (emr_odt_disable |-> !term_dq && !term_dm)
		else $error("termination on while disabled");
	a_sr_buffers: assert property (pwr_state == PWR_SELF_REF
		|-> !in_buf_en && !ck_buf_en)
		else $error("buffers active in self refresh");
	a_mask_drops: assert property ((dqs_e.rise || dqs_e.fall) && wr_window && active
		&& dm_s && mask_en |=> !wr_store)
		else $error("masked beat was stored");
	a_rdqs_no_mask: assert property ((dqs_e.rise || dqs_e.fall) && wr_window && active
		&& rdqs_mode |=> wr_store)
		else $error("beat masked while read strobe is on");
	a_rd_fall_beat: assert property (ck_e.fall && rd_valid && out_drv_en
		|=> dq_o == $past(rd_fall_data))
		else $error("falling edge read beat not launched");
	a_rdqs_mirror: assert property (rdqs_mode |-> dm_o == dqs_o && dm_oe == dqs_oe)
		else $error("read strobe differs from DQS");
endmodule

// >>> ddr2_host.sv
// Controller model driving DDR2 clock, command and write pins
`timescale 1ns/1ps
module ddr2_host (
	input wire logic clk_sys,
	output logic ck,
	output logic cke,
	output logic [3:0] code,
	output logic odt,
	output logic dqs,
	output logic [7:0] dq,
	output logic dm
);
	initial begin
		{ck, cke, odt, dqs, dq, dm} = 13'h0;
		code = 4'hF;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// CK pulses only to carry a command and stands low between them
	task automatic cmd(input logic k, input logic [3:0] c, input logic o);
		w(1);
		cke = k;
		code = c;
		odt = o;
		w(3);
		ck = 1'b1;
		w(3);
		code[3] = 1'b1; // Deselect after hold, so a falling-edge sampler would differ
		w(5);
		ck = 1'b0;
		w(4);
	endtask
	task automatic cke_set(input logic k);
		cke = k;
	endtask
	task automatic wr(input logic [7:0] d0, input logic m0, input logic [7:0] d1, input logic m1);
		w(1);
		cke = 1'b1;
		{dq, dm} = {d0, m0};
		w(4);
		dqs = 1'b1;
		w(4);
		{dq, dm} = {d1, m1};
		w(4);
		dqs = 1'b0;
		w(4);
		{dq, dm} = ~{d1, m1}; // Released data must not linger as a valid beat
		w(4);
	endtask
endmodule

// >>> ddr2_ctl_pins_tb_top.sv
// Self-checking bench for the DDR2 control pin interface
`timescale 1ns/1ps
module ddr2_ctl_pins_tb_top
	import ddr2_ctl_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ck, cke, cs_n, ras_n, cas_n, we_n, odt, hdqs, hdm, dqs_i, dm_i, row_open, rd_valid;
	logic [3:0] code, got_cmd;
	logic [7:0] hdq, dq_i, dq_o, rd_rise_data, rd_fall_data, wr_data, got_wd;
	logic [1:0] org;
	logic emr_odt_disable, emr_rdqs_enable, emr_dqs_n_disable, wr_window, wr_store, cmd_valid;
	logic dq_oe, dqs_o, dqs_oe, dqs_n_o, dqs_n_oe, dm_o, dm_oe, int_clk_en, in_buf_en;
	logic out_drv_en, ck_buf_en, term_dq, term_dqs, term_dqs_n, term_dm, term_rdqs;
	cmd_t cmd;
	pwr_t pwr_state;
	int err_count, cmp_count, n_cmd, n_st, cyc;
	always #2 clk_sys = ~clk_sys;
	assign {cs_n, ras_n, cas_n, we_n} = code;
	assign dq_i = dq_oe ? dq_o : hdq;
	assign dqs_i = dqs_oe ? dqs_o : hdqs;
	assign dm_i = dm_oe ? dm_o : hdm;
	ddr2_host i_ddr2_host (.clk_sys, .ck, .cke, .code, .odt, .dqs(hdqs), .dq(hdq), .dm(hdm));
	ddr2_ctl_pins i_ddr2_ctl_pins (.clk_sys, .rst, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt,
		.dq_i, .dq_o, .dq_oe, .dqs_i, .dqs_o, .dqs_oe, .dqs_n_o, .dqs_n_oe, .dm_i, .dm_o, .dm_oe,
		.org, .emr_odt_disable, .emr_rdqs_enable, .emr_dqs_n_disable, .row_open, .rd_valid,
		.rd_rise_data, .rd_fall_data, .wr_window, .cmd_valid, .cmd, .pwr_state, .int_clk_en,
		.in_buf_en, .out_drv_en, .ck_buf_en, .term_dq, .term_dqs, .term_dqs_n, .term_dm,
		.term_rdqs, .wr_data, .wr_store);
	task automatic finish_test();
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			got_cmd = cmd;
		end
		if (wr_store === 1'b1) begin
			n_st++;
			got_wd = wr_data;
		end
		if (cyc == 5000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk_v(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_b(input string n, input logic e, input logic g);
		chk_v(n, {7'h0, e}, {7'h0, g});
	endtask
	task automatic t_cmds();
		int n;
		for (int i = 0; i < 8; i++) begin
			n = n_cmd;
			i_ddr2_host.cmd(1'b1, {1'b0, 3'(i)}, 1'b0);
			chk_v("pulses", 8'(n + 1), 8'(n_cmd));
			chk_v("cmd", {4'h0, 4'(i)}, {4'h0, got_cmd});
		end
		i_ddr2_host.cmd(1'b1, 4'h8, 1'b0);
		chk_v("masked", 8'(n + 1), 8'(n_cmd));
		chk_v("desel", {4'h0, CMD_DESELECT}, {4'h0, cmd});
		$display("t_cmds done");
	endtask
	task automatic t_pwr();
		int n;
		i_ddr2_host.cmd(1'b0, 4'h7, 1'b0);
		chk_v("pwr", {6'h0, PWR_PRE_PD}, {6'h0, pwr_state});
		chk_b("inbuf", 1'b0, in_buf_en);
		chk_b("intclk", 1'b0, int_clk_en);
		chk_b("ckbuf", 1'b1, ck_buf_en);
		n = n_cmd;
		i_ddr2_host.cmd(1'b0, 4'h5, 1'b0);
		chk_v("pdcmd", 8'(n), 8'(n_cmd));
		i_ddr2_host.cmd(1'b1, 4'h7, 1'b0);
		chk_b("drv", 1'b1, out_drv_en);
		row_open = 1'b1;
		i_ddr2_host.cmd(1'b0, 4'h7, 1'b0);
		chk_v("pwr", {6'h0, PWR_ACT_PD}, {6'h0, pwr_state});
		row_open = 1'b0;
		i_ddr2_host.cmd(1'b1, 4'h7, 1'b0);
		i_ddr2_host.cmd(1'b0, 4'h1, 1'b0);
		chk_v("pwr", {6'h0, PWR_SELF_REF}, {6'h0, pwr_state});
		chk_b("ckbuf", 1'b0, ck_buf_en);
		i_ddr2_host.cke_set(1'b1);
		i_ddr2_host.w(6);
		chk_v("pwr", {6'h0, PWR_ACTIVE}, {6'h0, pwr_state});
		$display("t_pwr done");
	endtask
	task automatic t_write();
		int n;
		wr_window = 1'b1;
		n = n_st;
		i_ddr2_host.wr(8'hA5, 1'b0, 8'h3C, 1'b1);
		chk_v("wdata", 8'hA5, got_wd);
		i_ddr2_host.wr(8'h5A, 1'b1, 8'hC3, 1'b0);
		chk_v("stores", 8'(n + 2), 8'(n_st));
		chk_v("wdata", 8'hC3, got_wd);
		$display("t_write done");
	endtask
	task automatic t_odt();
		i_ddr2_host.cmd(1'b1, 4'h7, 1'b1);
		chk_b("tdq", 1'b1, term_dq);
		chk_b("tdqs", 1'b1, term_dqs);
		chk_b("tdqsn", 1'b1, term_dqs_n);
		emr_dqs_n_disable = 1'b1;
		#4;
		chk_b("tdqsn", 1'b0, term_dqs_n);
		{org, emr_rdqs_enable} = {ORG_X8, 1'b1};
		#4;
		chk_b("tdm", 1'b0, term_dm);
		chk_b("trdqs", 1'b1, term_rdqs);
		emr_odt_disable = 1'b1;
		#4;
		chk_b("tdq", 1'b0, term_dq);
		emr_odt_disable = 1'b0;
		i_ddr2_host.cmd(1'b1, 4'h7, 1'b0);
		chk_b("tdq", 1'b0, term_dq);
		$display("t_odt done");
	endtask
	task automatic t_read();
		int n;
		n = n_st;
		i_ddr2_host.wr(8'h11, 1'b1, 8'h22, 1'b1);
		chk_v("stores", 8'(n + 2), 8'(n_st));
		wr_window = 1'b0;
		{rd_valid, rd_rise_data, rd_fall_data} = {1'b1, 8'h96, 8'h69};
		fork
			i_ddr2_host.cmd(1'b1, 4'h7, 1'b0);
			begin
				i_ddr2_host.w(10);
				chk_v("rise", 8'h96, dq_o);
				chk_b("dqs", 1'b1, dqs_o);
				chk_b("dqoe", 1'b1, dq_oe);
				chk_b("dqsoe", 1'b1, dqs_oe);
				chk_b("dqsn", 1'b0, dqs_n_o);
				chk_b("rdqs", 1'b1, dm_o);
				chk_b("dmoe", 1'b1, dm_oe);
				chk_b("dqsnoe", 1'b0, dqs_n_oe);
				i_ddr2_host.w(5);
				chk_v("fall", 8'h69, dq_o);
				chk_b("dqs", 1'b0, dqs_o);
			end
		join
		rd_valid = 1'b0;
		$display("t_read done");
	endtask
	initial begin
		{org, emr_odt_disable, emr_rdqs_enable, emr_dqs_n_disable} = 5'h0;
		{row_open, rd_valid, wr_window, rd_rise_data, rd_fall_data} = 19'h0;
		repeat (10) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_cmds();
		t_pwr();
		t_write();
		t_odt();
		t_read();
		finish_test();
	end
endmodule
